// >>> src/qsd_pkg.sv
// Constants shared by the quad serial port address decoder
//
// Functional notes
// [R1] Each channel owns eight consecutive byte registers
// [R2] Divisor access clear selects eight general registers
// [R3] Divisor access set: offsets 0/1 divisor bytes
// [R4] One user pair: 16-byte window, 16-byte boundary
// [R5] Two user pairs: ignore bit four, 32-byte window
// [R6] User base comes out of reset at 180h
// [R7] Two map selects per pair pick port mapping
// [R8] Channel enable removed: channel never answers
// [R9] Zero-wait select fitted: assert zero wait state
// [R10] Each channel interrupt routed to one host line
// [R11] Configuring party keeps interrupt lines unshared
// [R12] Lines 10, 11, 15 need extension connector
// [R13] Isolated channel mode: point, multi-drop, half-duplex
// [R14] Shipped defaults for addresses, interrupts, modes
// [R15] User window holds pair at base, base+8
// [R16] Standard ports 3F8h, 2F8h, 3E8h, 2E8h
package qsd_pkg;

  // ------------------------------------------------------------
  // Channel and address geometry
  // ------------------------------------------------------------
  localparam int CHAN_COUNT = 4;
  localparam int IRQ_LINES = 8;
  localparam int ADDR_W = 10;
  localparam int CHAN_SPAN = 8;
  localparam logic [9:0] PAIR_STRIDE = 10'h008;

  // Standard port bases, index 0 is port 1
  localparam logic [3:0][9:0] STD_BASE = {10'h2e8, 10'h3e8, 10'h2f8, 10'h3f8};

  // Pair map code {high, low} that selects the user window
  localparam logic [1:0] MAP_USER = 2'h3;

  // Line control bit that flips offsets 0/1 to the divisor
  localparam int LCR_DIVISOR_LATCH_ACCESS_BIT_BIT = 7;
  localparam logic [2:0] OFS_HOLD = 3'h0;
  localparam logic [2:0] OFS_IER = 3'h1;
  localparam logic [2:0] OFS_LCR = 3'h3;

  // ------------------------------------------------------------
  // Register identities reported with each decoded access
  // ------------------------------------------------------------
  localparam logic [3:0] REG_HOLDING_DATA = 4'h0;
  localparam logic [3:0] REG_INTERRUPT_ENABLE = 4'h1;
  localparam logic [3:0] REG_INT_STATUS_FIFO_CTRL = 4'h2;
  localparam logic [3:0] REG_LINE_CONTROL = 4'h3;
  localparam logic [3:0] REG_MODEM_CONTROL = 4'h4;
  localparam logic [3:0] REG_LINE_STATUS = 4'h5;
  localparam logic [3:0] REG_MODEM_STATUS = 4'h6;
  localparam logic [3:0] REG_SCRATCH_BYTE = 4'h7;
  localparam logic [3:0] REG_DIVISOR_LOW_BYTE = 4'h8;
  localparam logic [3:0] REG_DIVISOR_HIGH_BYTE = 4'h9;

  // ------------------------------------------------------------
  // Host interrupt line indices: 3,4,5,7,9,10,11,15
  // ------------------------------------------------------------
  localparam logic [2:0] IRQ_IDX_3 = 3'h0;
  localparam logic [2:0] IRQ_IDX_4 = 3'h1;
  localparam logic [2:0] IRQ_IDX_10 = 3'h5;
  localparam logic [2:0] IRQ_IDX_11 = 3'h6;

  // ------------------------------------------------------------
  // Values taken at reset (shipped configuration)
  // ------------------------------------------------------------
  localparam logic [5:0] RST_USER_BASE = 6'h18;
  localparam logic [3:0] RST_PAIR_MAP = 4'hb;
  localparam logic [3:0] RST_CHAN_ENABLE = 4'hf;
  localparam logic RST_ZERO_WAIT = 1'b1;
  localparam logic [11:0] RST_IRQ_SEL = {IRQ_IDX_3, IRQ_IDX_4, IRQ_IDX_10, IRQ_IDX_11};
  localparam logic [3:0] RST_MODE_SEL = 4'hf;

endpackage : qsd_pkg

// >>> src/qsd_decoder.sv
// Quad serial port address decoder, interrupt router and mode steering
`timescale 1ns/1ps

module qsd_decoder
  import qsd_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Host expansion bus
  input wire logic [9:0] i_addr,
  input wire logic i_aen,
  input wire logic i_ior,
  input wire logic i_iow,
  input wire logic [7:0] i_data,
  // Configuration jumpers
  input wire logic [5:0] i_user_base_select,
  input wire logic [3:0] i_pair_map_select,
  input wire logic [3:0] i_channel_enable_select,
  input wire logic i_zero_wait_select,
  input wire logic [2:0] i_chan_a_irq_select,
  input wire logic [2:0] i_chan_b_irq_select,
  input wire logic [2:0] i_chan_c_irq_select,
  input wire logic [2:0] i_chan_d_irq_select,
  input wire logic i_chan_a_mode_select_first,
  input wire logic i_chan_a_mode_select_second,
  input wire logic i_chan_b_mode_select_first,
  input wire logic i_chan_b_mode_select_second,
  // UART interrupt requests, one per channel
  input wire logic [3:0] i_uart_irq,
  // UART selects
  output logic [3:0] o_chan_select,
  output logic [2:0] o_reg_offset,
  output logic [3:0] o_reg_id,
  output logic o_read_strobe,
  output logic o_write_strobe,
  // Bus answers
  output logic o_zero_wait,
  output logic [7:0] o_host_irq,
  output logic o_extension_needed,
  // Isolated channel wiring, bit 0 channel A, bit 1 channel B
  output logic [1:0] o_shared_transmit_pair,
  output logic [1:0] o_multi_drop
);

  // ------------------------------------------------------------
  // State record
  // ------------------------------------------------------------
  typedef struct packed {
    logic [5:0] cfg_base;     // User base bits 9..4
    logic [3:0] cfg_map;      // {second high, second low, first high, first low}
    logic [3:0] cfg_en;       // Channel enables
    logic cfg_zws;            // Zero wait fitted
    logic [11:0] cfg_irq;     // Line index per channel, A in low bits
    logic [3:0] cfg_mode;     // {B second, B first, A second, A first}
    logic [3:0] divisor_latch_access_bit;         // Divisor access copy per channel
    logic [3:0] chan_sel;     // One-hot UART select
    logic [2:0] reg_offset;   // Offset inside the window
    logic [3:0] reg_id;       // Register meant by the access
    logic rd;                 // Read strobe
    logic wr;                 // Write strobe
    logic zws;                // Zero-wait answer
    logic [7:0] irq;          // Routed host lines
    logic ext;                // Extension connector lines in use
    logic [1:0] shared_pair;  // Half duplex on transmit pair
    logic [1:0] multi;        // Multi-drop transmit gating
  } qsd_state_type;

  qsd_state_type st;       // Registered state
  qsd_state_type next_st;  // Next state

  // ------------------------------------------------------------
  // Per-channel window placement
  // ------------------------------------------------------------
  logic [3:0] chan_hit;         // Address falls in channel window
  logic [3:0][9:0] chan_base;   // Window base per channel

  for (genvar c = 0; c < CHAN_COUNT; c++) begin : g_chan
    logic [1:0] map;        // Map code of this channel's pair
    logic [1:0] std_idx;    // Standard port index
    logic [9:0] user_base;  // Base inside the user window
    assign map = st.cfg_map[2*(c/2) +: 2];
    // Second channel of a pair takes the next standard port
    assign std_idx = map + 2'(c % 2); // R7
    // Both pairs user: 32-byte window, bit four ignored
    assign user_base = (st.cfg_map == 4'hf) ?
      ({st.cfg_base[5:1], 5'h00} + 10'(c * CHAN_SPAN)) : // R5
      ({st.cfg_base, 4'h0} + ((c % 2 == 1) ? PAIR_STRIDE : 10'h000)); // R4 R15
    assign chan_base[c] = (map == MAP_USER) ? user_base : STD_BASE[std_idx]; // R16
    // Eight-byte match gated by the channel enable
    assign chan_hit[c] = st.cfg_en[c] && (i_addr[9:3] == chan_base[c][9:3]); // R1 R8
  end

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    logic access;      // Live I/O cycle on the bus
    logic [3:0] sel;   // Prioritised select
    logic sel_divisor_latch_access_bit;    // Divisor access of selected channel
    next_st = st;
    access = !i_aen && (i_ior || i_iow);
    sel = 4'h0;
    sel_divisor_latch_access_bit = 1'b0;
    // Jumpers followed every cycle after reset
    next_st.cfg_base = i_user_base_select;
    next_st.cfg_map = i_pair_map_select;
    next_st.cfg_en = i_channel_enable_select;
    next_st.cfg_zws = i_zero_wait_select;
    next_st.cfg_irq = {i_chan_d_irq_select, i_chan_c_irq_select,
                       i_chan_b_irq_select, i_chan_a_irq_select};
    next_st.cfg_mode = {i_chan_b_mode_select_second, i_chan_b_mode_select_first,
                        i_chan_a_mode_select_second, i_chan_a_mode_select_first};
    // Lowest channel wins where windows overlap
    for (int c = CHAN_COUNT - 1; c >= 0; c--) begin
      if (access && chan_hit[c]) begin
        sel = 4'h0;
        sel[c] = 1'b1;
        sel_divisor_latch_access_bit = st.divisor_latch_access_bit[c];
      end
    end
    next_st.chan_sel = sel;
    next_st.reg_offset = i_addr[2:0];
    next_st.rd = (sel != 4'h0) && i_ior;
    next_st.wr = (sel != 4'h0) && i_iow;
    // Zero wait only on our own accesses
    next_st.zws = st.cfg_zws && (sel != 4'h0); // R9
    // Register identity from offset and divisor access
    if (sel_divisor_latch_access_bit && (i_addr[2:0] == OFS_HOLD)) begin
      next_st.reg_id = REG_DIVISOR_LOW_BYTE; // R3
    end else if (sel_divisor_latch_access_bit && (i_addr[2:0] == OFS_IER)) begin
      next_st.reg_id = REG_DIVISOR_HIGH_BYTE; // R3
    end else begin
      next_st.reg_id = {1'b0, i_addr[2:0]}; // R2
    end
    // Snoop line control writes for the divisor access bit
    for (int c = 0; c < CHAN_COUNT; c++) begin
      if (sel[c] && i_iow && (i_addr[2:0] == OFS_LCR)) begin
        next_st.divisor_latch_access_bit[c] = i_data[LCR_DIVISOR_LATCH_ACCESS_BIT_BIT]; // R2 R3
      end
    end
    // Route each UART request to its one host line
    next_st.irq = 8'h00;
    next_st.ext = 1'b0;
    for (int c = 0; c < CHAN_COUNT; c++) begin
      if (st.cfg_en[c]) begin
        next_st.irq[st.cfg_irq[3*c +: 3]] = next_st.irq[st.cfg_irq[3*c +: 3]]
                                            | i_uart_irq[c]; // R10
        // Lines 10, 11 and 15 sit on the extension connector
        if (st.cfg_irq[3*c +: 3] >= IRQ_IDX_10) begin
          next_st.ext = 1'b1; // R12
        end
      end
    end
    // Isolated channel wiring from the mode selects
    for (int c = 0; c < 2; c++) begin
      next_st.shared_pair[c] = st.cfg_mode[2*c] && st.cfg_mode[2*c+1]; // R13
      next_st.multi[c] = !st.cfg_mode[2*c] && st.cfg_mode[2*c+1]; // R13
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      st <= '0;
      // Shipped configuration until the jumpers are sampled
      st.cfg_base <= RST_USER_BASE; // R6 R14
      st.cfg_map <= RST_PAIR_MAP; // R7 R14
      st.cfg_en <= RST_CHAN_ENABLE; // R8
      st.cfg_zws <= RST_ZERO_WAIT; // R9
      st.cfg_irq <= RST_IRQ_SEL; // R14
      st.cfg_mode <= RST_MODE_SEL; // R13 R14
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // Outputs straight from the state register
  // ------------------------------------------------------------
  assign o_chan_select = st.chan_sel;
  assign o_reg_offset = st.reg_offset;
  assign o_reg_id = st.reg_id;
  assign o_read_strobe = st.rd;
  assign o_write_strobe = st.wr;
  assign o_zero_wait = st.zws;
  assign o_host_irq = st.irq;
  assign o_extension_needed = st.ext;
  assign o_shared_transmit_pair = st.shared_pair;
  assign o_multi_drop = st.multi;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);

  // Never more than one UART selected
  a_select_one_hot: assert property ($onehot0(o_chan_select)) // R1
    else $error("more than one channel selected");

  // Select follows a live cycle on the channel window
  a_select_cause: assert property (
    (!i_aen && i_ior && chan_hit[0]) |=> (o_chan_select == 4'h1 && o_read_strobe)) // R1
    else $error("channel A hit not selected");

  // Divisor bit set turns offset 0 into the divisor low byte
  // Host leaves one idle cycle between accesses, so allow a quiet gap
  a_divisor_low: assert property (
    (!i_aen && i_iow && chan_hit[0] && i_addr[2:0] == OFS_LCR && i_data[7])
    ##1 (!i_iow)
    ##1 (!i_aen && i_ior && chan_hit[0] && i_addr[2:0] == OFS_HOLD)
    |=> (o_reg_id == REG_DIVISOR_LOW_BYTE)) // R3
    else $error("divisor low byte not selected");

  // Divisor bit clear keeps the general set
  a_general_set: assert property (
    (o_chan_select != 4'h0 && !st.divisor_latch_access_bit[0] && o_chan_select[0]) |-> !o_reg_id[3]) // R2
    else $error("general register expected");

  // Both pairs user: channel D window 18h above the 32-byte base
  a_user_wide: assert property (
    (st.cfg_map == 4'hf) |-> (chan_base[3] == {st.cfg_base[5:1], 5'h18})) // R5
    else $error("32-byte window placement wrong");

  // One pair user: second channel at base plus eight
  a_user_pair: assert property (
    (st.cfg_map[1:0] == MAP_USER && st.cfg_map[3:2] != MAP_USER)
    |-> (chan_base[1] == {st.cfg_base, 4'h8})) // R4 R15
    else $error("16-byte window placement wrong");

  // Disabled channel never selected
  a_enable_gate: assert property (
    (!i_channel_enable_select[2]) |=> ##1 !o_chan_select[2]) // R8
    else $error("disabled channel answered");

  // Zero wait only with the jumper fitted and a select
  a_zero_wait: assert property (
    o_zero_wait |-> ($past(st.cfg_zws) && o_chan_select != 4'h0)) // R9
    else $error("zero wait without cause");

  // Standard map: pair code 2 puts channel D at port 4
  a_std_port: assert property (
    (st.cfg_map[3:2] == 2'h2) |-> (chan_base[3] == 10'h2e8)) // R16 R7
    else $error("port 4 base wrong");

  // UART request reaches its routed line a cycle later
  a_irq_route: assert property (
    (i_uart_irq[0] && st.cfg_en[0] && $stable(st.cfg_irq))
    |=> o_host_irq[$past(st.cfg_irq[2:0])]) // R10
    else $error("interrupt not routed");

  // Reset leaves the shipped user base
  a_reset_base: assert property (
    @(posedge i_clk_sys) disable iff (1'b0)
    $fell(i_srst) |-> (st.cfg_base == RST_USER_BASE)) // R6
    else $error("user base not 180h after reset");

  // Half duplex only for both selects in B position
  a_mode_half: assert property (
    o_shared_transmit_pair[0] |-> ($past(st.cfg_mode[1:0]) == 2'h3 && !o_multi_drop[0])) // R13
    else $error("half duplex mode wrong");

  cv_divisor: cover property (o_reg_id == REG_DIVISOR_HIGH_BYTE && o_write_strobe);
  cv_user_all: cover property (st.cfg_map == 4'hf && o_chan_select == 4'h8);
  cv_irq_ext: cover property (o_extension_needed && o_host_irq[7]);

endmodule : qsd_decoder

// >>> testbench/qsd_host_model.sv
// Host CPU board model driving expansion bus I/O cycles
`timescale 1ns/1ps

module qsd_host_model (
  // Clock
  input wire logic i_clk_sys,
  // Expansion bus
  output logic [9:0] o_addr,
  output logic o_aen,
  output logic o_ior,
  output logic o_iow,
  output logic [7:0] o_data
);
  // Idle bus at time zero
  initial begin
    o_addr = 10'h3ff;
    o_aen = 1'b0;
    o_ior = 1'b0;
    o_iow = 1'b0;
    o_data = 8'hff;
  end

  // One byte cycle, held over exactly one sampling edge
  task automatic io_cycle(input logic [9:0] addr, input logic wr, input logic [7:0] data,
                          input logic dma);
    @(posedge i_clk_sys);
    o_addr <= addr;
    o_aen <= dma;
    o_iow <= wr;
    o_ior <= ~wr;
    o_data <= data;
    @(posedge i_clk_sys);
    // Released lines stop showing the old value
    o_iow <= 1'b0;
    o_ior <= 1'b0;
    o_aen <= 1'b0;
    o_addr <= ~addr;
    o_data <= ~data;
    #1;
  endtask : io_cycle
endmodule : qsd_host_model

// >>> testbench/qsd_testbench.sv
// Self-checking testbench for the quad serial port address decoder
`timescale 1ns/1ps

module testbench
  import qsd_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [9:0] addr;
  logic aen, ior, iow;
  logic [7:0] data;
  // Jumpers start at shipped values
  logic [5:0] user_base = RST_USER_BASE;
  logic [3:0] pair_map = RST_PAIR_MAP;
  logic [3:0] chan_en = 4'hf;
  logic zw_sel = 1'b1;
  logic [2:0] irq_sel [4] = '{3'h6, 3'h5, 3'h1, 3'h0};
  logic [3:0] mode = 4'hf;
  logic [3:0] uart_irq = 4'h0;
  logic [3:0] chan_select, reg_id;
  logic [2:0] reg_offset;
  logic read_strobe, write_strobe, zero_wait, ext_needed;
  logic [7:0] host_irq;
  logic [1:0] shared_pair, multi_drop;
  int failures = 0;
  int checks_done = 0;
  localparam logic [9:0] DEF_ADDR [4] = '{10'h180, 10'h188, 10'h3e8, 10'h2e8};

  // 40 MHz clock
  always #12.5 clk_sys = ~clk_sys;

  qsd_host_model qsd_host_model_i (.i_clk_sys(clk_sys), .o_addr(addr), .o_aen(aen),
    .o_ior(ior), .o_iow(iow), .o_data(data));

  qsd_decoder qsd_decoder_i (.i_clk_sys(clk_sys), .i_srst(srst), .i_addr(addr),
    .i_aen(aen), .i_ior(ior), .i_iow(iow), .i_data(data), .i_user_base_select(user_base),
    .i_pair_map_select(pair_map), .i_channel_enable_select(chan_en),
    .i_zero_wait_select(zw_sel), .i_chan_a_irq_select(irq_sel[0]),
    .i_chan_b_irq_select(irq_sel[1]), .i_chan_c_irq_select(irq_sel[2]),
    .i_chan_d_irq_select(irq_sel[3]), .i_chan_a_mode_select_first(mode[0]),
    .i_chan_a_mode_select_second(mode[1]), .i_chan_b_mode_select_first(mode[2]),
    .i_chan_b_mode_select_second(mode[3]), .i_uart_irq(uart_irq),
    .o_chan_select(chan_select), .o_reg_offset(reg_offset), .o_reg_id(reg_id),
    .o_read_strobe(read_strobe), .o_write_strobe(write_strobe), .o_zero_wait(zero_wait),
    .o_host_irq(host_irq), .o_extension_needed(ext_needed),
    .o_shared_transmit_pair(shared_pair), .o_multi_drop(multi_drop));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // One access and the decode it should give
  task automatic probe(input logic [9:0] a, input logic wr, input logic [7:0] d,
                       input logic [3:0] sel, input logic [3:0] id);
    qsd_host_model_i.io_cycle(a, wr, d, 1'b0);
    check(chan_select, sel, "select");
    if (sel != 4'h0) begin
      check(reg_id, id, "register");
      check(reg_offset, a[2:0], "offset");
      check({read_strobe, write_strobe}, {~wr, wr}, "strobes");
    end
    check(zero_wait, zw_sel & (sel != 4'h0), "zero wait");
  endtask : probe

  // New jumpers, then time for them to reach the outputs
  task automatic cfg(input logic [3:0] map, input logic [3:0] en, input logic [5:0] base);
    @(posedge clk_sys);
    pair_map <= map;
    chan_en <= en;
    user_base <= base;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : cfg

  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_defaults();
    for (int c = 0; c < 4; c++) begin
      probe(DEF_ADDR[c], 1'b1, 8'h00, 4'(1 << c), 4'h0);
    end
    probe(10'h3f8, 1'b0, 8'h00, 4'h0, 4'h0);
    @(posedge clk_sys);
    uart_irq <= 4'hf;
    repeat (2) @(posedge clk_sys);
    #1;
    check(host_irq, 8'h63, "irq lines");
    check(ext_needed, 1'b1, "extension");
    check({shared_pair, multi_drop}, 4'hc, "modes");
  endtask : t_defaults

  task automatic t_offsets();
    for (int o = 0; o < 8; o++) begin
      probe(10'h180 + 10'(o), 1'b1, 8'h00, 4'h1, 4'(o));
    end
    probe(10'h183, 1'b1, 8'h80, 4'h1, REG_LINE_CONTROL);
    probe(10'h180, 1'b0, 8'h00, 4'h1, REG_DIVISOR_LOW_BYTE);
    probe(10'h181, 1'b0, 8'h00, 4'h1, REG_DIVISOR_HIGH_BYTE);
    probe(10'h182, 1'b0, 8'h00, 4'h1, REG_INT_STATUS_FIFO_CTRL);
    probe(10'h188, 1'b0, 8'h00, 4'h2, REG_HOLDING_DATA);
    probe(10'h183, 1'b1, 8'h00, 4'h1, REG_LINE_CONTROL);
    probe(10'h181, 1'b0, 8'h00, 4'h1, REG_INTERRUPT_ENABLE);
  endtask : t_offsets

  task automatic t_map();
    for (int c = 0; c < 3; c++) begin
      cfg({2'h3, 2'(c)}, 4'hf, 6'h19);
      probe(STD_BASE[c], 1'b1, 8'h00, 4'h1, 4'h0);
      probe(STD_BASE[c+1], 1'b1, 8'h00, 4'h2, 4'h0);
      probe(10'h198, 1'b1, 8'h00, 4'h8, 4'h0);
      probe(10'h180, 1'b1, 8'h00, 4'h0, 4'h0);
      cfg({2'(c), 2'h3}, 4'hf, 6'h19);
      probe(10'h190, 1'b1, 8'h00, 4'h1, 4'h0);
      probe(STD_BASE[c+1], 1'b1, 8'h00, 4'h8, 4'h0);
    end
    cfg(4'hf, 4'hf, 6'h19);
    probe(10'h180, 1'b1, 8'h00, 4'h1, 4'h0);
    probe(10'h19f, 1'b1, 8'h00, 4'h8, 4'h7);
    cfg(4'h7, 4'hf, 6'h3f);
    probe(10'h3f8, 1'b1, 8'h00, 4'h2, 4'h0);
    cfg(4'hf, 4'hf, 6'h3f);
    probe(10'h3e8, 1'b1, 8'h00, 4'h2, 4'h0);
  endtask : t_map

  task automatic t_enable();
    for (int c = 0; c < 4; c++) begin
      cfg(RST_PAIR_MAP, ~(4'h1 << c), RST_USER_BASE);
      probe(DEF_ADDR[c], 1'b0, 8'h00, 4'h0, 4'h0);
      probe(DEF_ADDR[3-c], 1'b0, 8'h00, 4'(1 << (3 - c)), 4'h0);
    end
    cfg(RST_PAIR_MAP, 4'hf, RST_USER_BASE);
    qsd_host_model_i.io_cycle(10'h188, 1'b0, 8'h00, 1'b1);
    check({chan_select, zero_wait}, 5'h00, "dma cycle");
    @(posedge clk_sys);
    zw_sel <= 1'b0;
    cfg(RST_PAIR_MAP, 4'hf, RST_USER_BASE);
    probe(10'h180, 1'b1, 8'h00, 4'h1, 4'h0);
  endtask : t_enable

  task automatic t_irq();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      irq_sel[0] <= 3'(i);
      cfg(RST_PAIR_MAP, 4'h1, RST_USER_BASE);
      check(host_irq, 8'h01 << i, "routed line");
      check(ext_needed, i >= 5, "extension");
    end
    @(posedge clk_sys);
    irq_sel <= '{3'h7, 3'h2, 3'h1, 3'h0};
    uart_irq <= 4'h5;
    cfg(RST_PAIR_MAP, 4'hf, RST_USER_BASE);
    check(host_irq, 8'h82, "distinct lines");
  endtask : t_irq

  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys);
      mode <= {~2'(m), 2'(m)};
      repeat (3) @(posedge clk_sys);
      #1;
      check({shared_pair, multi_drop}, {mode[3] & mode[2], mode[1] & mode[0],
            mode[3] & ~mode[2], mode[1] & ~mode[0]}, "mode");
    end
  endtask : t_modes

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    conclude();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    t_defaults();
    t_offsets();
    t_map();
    t_enable();
    t_irq();
    t_modes();
    conclude();
  end
endmodule : testbench
